/* File: rtl/adcc_ctrl.v */
// converter control: apb registers, trigger selection, sequencing of the
// delay, sampling and conversion phases, result capture
// assumes the analog core runs its approximation on adc_clk_tick and
// answers conv_done with conv_result on pclk; the four trigger pins are asynchronous, the pwm centre, period-end and alignment lines come on pclk
`timescale 1ns/1ps
`default_nettype none
`include "adcc_regs.vh"

module adcc_ctrl (
  // apb slave
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // trigger sources
  input wire motor_pwm_out_a,
  input wire motor_pwm_out_c,
  input wire motor_pwm_out_e,
  input wire external_start_pin,
  input wire pwm_centre_point,
  input wire pwm_period_end,
  input wire pwm_centre_aligned,
  // analog core
  input wire conv_done,
  input wire [9:0] conv_result,
  output reg converter_power_on,
  output reg reference_source_sel,
  output reg [10:0] input_connect,
  output reg adc_clk_tick,
  output reg sample_hold,
  output reg conv_go
);

  // ----------------------------------------------------------------
  // sequencer states
  // ----------------------------------------------------------------
  localparam [3:0] ST_IDLE = 4'b0001;
  localparam [3:0] ST_DELAY = 4'b0010;
  localparam [3:0] ST_SAMPLE = 4'b0100;
  localparam [3:0] ST_CONV = 4'b1000;

  // reset images of the control registers, fields picked out below
  localparam [7:0] RST_A = `ADCC_RST_CTRL_A;
  localparam [7:0] RST_B = `ADCC_RST_CTRL_B;

  function hit;
    input [11:0] addr;
    input [7:0] idx;
    begin
      hit = (addr == {2'b00, idx, 2'b00});
    end
  endfunction

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  reg conversion_done_flag;
  reg start_busy_bit;
  reg [1:0] hw_trigger_source_sel;
  reg [3:0] input_channel_sel;
  reg [2:0] conv_clock_divider;
  reg [1:0] hw_trigger_type_sel;
  reg hw_trigger_allow;
  reg [8:0] trigger_delay_count;
  reg [7:0] sample_time_extend;
  reg [9:0] conversion_result;
  reg [3:0] state;
  reg [8:0] phase_cnt;
  reg [6:0] div_cnt;
  reg [3:0] sync_a;
  reg [3:0] sync_b;
  reg [3:0] trig_prev;

  wire wr_en = psel & penable & pready & pwrite;
  wire wr_a = wr_en & hit(paddr, `ADCC_IDX_CTRL_A);
  wire wr_b = wr_en & hit(paddr, `ADCC_IDX_CTRL_B);
  wire wr_dly = wr_en & hit(paddr, `ADCC_IDX_DELAY);
  wire wr_acq = wr_en & hit(paddr, `ADCC_IDX_ACQ);
  wire setup = psel & ~penable;

  // ----------------------------------------------------------------
  // converter clock divider
  // ----------------------------------------------------------------
  // a tick every 2**code system clocks; the mask keeps the low code bits
  wire [6:0] div_mask = 7'h7F >> (3'd7 - conv_clock_divider);
  wire tick = ((div_cnt & div_mask) == div_mask); // see (RQ9)

  // ----------------------------------------------------------------
  // trigger detection
  // ----------------------------------------------------------------
  wire [3:0] trig_raw = {external_start_pin, motor_pwm_out_e,
                         motor_pwm_out_c, motor_pwm_out_a};
  wire sel_now = sync_b[hw_trigger_source_sel]; // see (RQ5)
  wire sel_prev = trig_prev[hw_trigger_source_sel];
  reg hw_event;

  always @* begin
    case (hw_trigger_type_sel) // see (RQ10)
      `ADCC_TYP_FALL: hw_event = sel_prev & ~sel_now;
      `ADCC_TYP_RISE: hw_event = ~sel_prev & sel_now;
      `ADCC_TYP_CENTRE: hw_event = pwm_centre_aligned & pwm_centre_point; // see (RQ11)
      default: hw_event = pwm_centre_aligned & pwm_period_end; // see (RQ11)
    endcase
  end

  // blocked while busy or while the done flag is still up
  wire can_start = ~start_busy_bit & ~conversion_done_flag; // see (RQ2) (RQ14) (RQ19)
  wire sw_start = wr_a & pwdata[`ADCC_A_BUSY]; // see (RQ3)
  wire hw_start = hw_trigger_allow & hw_event; // see (RQ12) (RQ13)
  wire go_sw = can_start & sw_start;
  wire go_hw = can_start & ~sw_start & hw_start;
  // power off abandons the conversion, so a late answer must not set done
  wire finish = state[3] & conv_done & converter_power_on;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_a <= 4'h0;
      sync_b <= 4'h0;
      trig_prev <= 4'h0;
      div_cnt <= 7'h00;
      adc_clk_tick <= 1'b0;
    end else begin
      sync_a <= trig_raw;
      sync_b <= sync_a;
      trig_prev <= sync_b;
      div_cnt <= div_cnt + 7'h01;
      adc_clk_tick <= tick & converter_power_on;
    end
  end

  // ----------------------------------------------------------------
  // control registers and flags
  // ----------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conversion_done_flag <= RST_A[`ADCC_A_DONE];
      hw_trigger_source_sel <= 2'h0;
      input_channel_sel <= 4'h0;
      reference_source_sel <= 1'b0;
      conv_clock_divider <= RST_B[`ADCC_B_DIV_HI:`ADCC_B_DIV_LO]; // see (RQ9)
      hw_trigger_type_sel <= 2'h0;
      hw_trigger_allow <= 1'b0;
      converter_power_on <= 1'b0;
      trigger_delay_count <= `ADCC_RST_DELAY;
      sample_time_extend <= `ADCC_RST_ACQ;
      conversion_result <= 10'h000;
    end else begin
      if (wr_a) begin
        hw_trigger_source_sel <= pwdata[`ADCC_A_SRC_HI:`ADCC_A_SRC_LO];
        input_channel_sel <= pwdata[`ADCC_A_CH_HI:`ADCC_A_CH_LO];
      end
      // a completion in the clearing cycle wins over the clear
      if (finish) begin
        conversion_done_flag <= 1'b1; // see (RQ1) (RQ20)
        conversion_result <= conv_result; // see (RQ16)
      end else if (wr_a & ~pwdata[`ADCC_A_DONE]) begin
        conversion_done_flag <= 1'b0; // see (RQ1)
      end
      if (wr_b) begin
        reference_source_sel <= pwdata[`ADCC_B_REF]; // see (RQ8)
        conv_clock_divider <= pwdata[`ADCC_B_DIV_HI:`ADCC_B_DIV_LO]; // see (RQ9)
        hw_trigger_type_sel <= pwdata[`ADCC_B_TYP_HI:`ADCC_B_TYP_LO];
        hw_trigger_allow <= pwdata[`ADCC_B_HWTRIG];
        converter_power_on <= pwdata[`ADCC_B_PWR]; // see (RQ15)
      end
      if (wr_dly) begin
        trigger_delay_count <= pwdata[8:0];
      end
      if (wr_acq) begin
        sample_time_extend <= pwdata[7:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // sequencer: delay, sample, convert
  // ----------------------------------------------------------------
  // switching the converter off abandons a conversion in flight
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_IDLE;
      start_busy_bit <= 1'b0;
      phase_cnt <= 9'h000;
      sample_hold <= 1'b0;
      conv_go <= 1'b0;
    end else begin
      conv_go <= 1'b0;
      if (!converter_power_on && !state[0]) begin
        state <= ST_IDLE;
        start_busy_bit <= 1'b0;
        sample_hold <= 1'b0;
      end else begin
        case (state)
          ST_IDLE: begin
            if (go_sw) begin
              start_busy_bit <= 1'b1; // see (RQ3) (RQ4)
              state <= ST_SAMPLE;
              phase_cnt <= `ADCC_SAMPLE_BASE + {1'b0, sample_time_extend}; // see (RQ18)
              sample_hold <= 1'b1;
            end else if (go_hw) begin
              start_busy_bit <= 1'b1; // see (RQ13)
              state <= ST_DELAY;
              phase_cnt <= trigger_delay_count; // see (RQ17)
            end
          end
          ST_DELAY: begin
            if (phase_cnt == 9'h000) begin
              state <= ST_SAMPLE;
              phase_cnt <= `ADCC_SAMPLE_BASE + {1'b0, sample_time_extend}; // see (RQ18)
              sample_hold <= 1'b1;
            end else if (tick) begin
              phase_cnt <= phase_cnt - 9'h001; // see (RQ17)
            end
          end
          ST_SAMPLE: begin
            if (tick) begin
              if (phase_cnt == 9'h001) begin
                state <= ST_CONV;
                sample_hold <= 1'b0;
                conv_go <= 1'b1;
              end
              phase_cnt <= phase_cnt - 9'h001; // see (RQ18)
            end
          end
          ST_CONV: begin
            if (conv_done) begin
              start_busy_bit <= 1'b0; // see (RQ4) (RQ20)
              state <= ST_IDLE;
            end
          end
          default: begin
            state <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // analog input routing
  // ----------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      input_connect <= 11'h000;
    end else if (!converter_power_on) begin
      input_connect <= 11'h000; // see (RQ7)
    end else if (input_channel_sel == `ADCC_CH_BANDGAP) begin
      input_connect <= 11'h400; // see (RQ6)
    end else if (input_channel_sel <= `ADCC_CH_LAST) begin
      input_connect <= 11'h001 << input_channel_sel; // see (RQ6)
    end else begin
      input_connect <= 11'h000; // see (RQ6)
    end
  end

  // ----------------------------------------------------------------
  // apb read path, zero wait states
  // ----------------------------------------------------------------
  // read data is prepared in the setup cycle so it stands in the access
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= 1'b1;
      if (setup) begin
        pslverr <= 1'b0;
        if (hit(paddr, `ADCC_IDX_CTRL_A)) begin
          prdata <= {24'h000000, conversion_done_flag, start_busy_bit,
                     hw_trigger_source_sel, input_channel_sel};
        end else if (hit(paddr, `ADCC_IDX_CTRL_B)) begin
          prdata <= {24'h000000, reference_source_sel, conv_clock_divider,
                     hw_trigger_type_sel, hw_trigger_allow,
                     converter_power_on};
        end else if (hit(paddr, `ADCC_IDX_DELAY)) begin
          prdata <= {23'h000000, trigger_delay_count};
        end else if (hit(paddr, `ADCC_IDX_ACQ)) begin
          prdata <= {24'h000000, sample_time_extend};
        end else if (hit(paddr, `ADCC_IDX_RES_HI)) begin
          prdata <= {24'h000000, conversion_result[9:2]}; // see (RQ16)
        end else if (hit(paddr, `ADCC_IDX_RES_LO)) begin
          prdata <= {30'h00000000, conversion_result[1:0]}; // see (RQ16)
        end else begin
          prdata <= 32'h0000_0000;
          pslverr <= 1'b1;
        end
      end
    end
  end

endmodule // adcc_ctrl
`default_nettype wire

/* File: rtl/adcc_regs.vh */
// register indices, field positions and reset values of the converter control
// assumes a bus slave that places register index n at byte address 4*n
//
// Functional notes
// (RQ1) done flag set on completion, held until software writes zero
// (RQ2) no new conversion starts while the done flag is set
// (RQ3) writing one to start/busy launches a conversion, zero does nothing
// (RQ4) start/busy reads one during conversion, hardware clears it at the end
// (RQ5) trigger source: 00 pwm a, 01 pwm c, 10 pwm e, 11 external pin
// (RQ6) channel codes 0..9 pick inputs, 1111 the band-gap, others reserved
// (RQ7) converter disabled disconnects every analog input
// (RQ8) reference bit zero picks supply, one the external reference pin
// (RQ9) converter clock is system clock over two to the code, reset code 010
// (RQ10) trigger type: falling, rising, period centre, period end
// (RQ11) centre and end triggers only while pwm is centre aligned
// (RQ12) hardware trigger disallowed means only software starts count
// (RQ13) hardware trigger allowed adds the selected event, which sets busy
// (RQ14) trigger events during a conversion are dropped without record
// (RQ15) enable bit powers the converter on or off
// (RQ16) result upper eight bits to high register, low two to low register
// (RQ17) a hardware trigger waits the 9-bit delay count before converting
// (RQ18) sampling lasts six converter clocks plus the acquisition value
// (RQ19) a software start during a conversion is ignored silently
// (RQ20) done flag set and busy cleared together, with the result stored
`ifndef ADCC_REGS_VH
`define ADCC_REGS_VH

// register indices; byte address is four times the index
`define ADCC_IDX_CTRL_B 8'hE1
`define ADCC_IDX_CTRL_A 8'hE8
`define ADCC_IDX_DELAY 8'hE3
`define ADCC_IDX_ACQ 8'hF2
`define ADCC_IDX_RES_HI 8'hC3
`define ADCC_IDX_RES_LO 8'hC2

// control a fields
`define ADCC_A_DONE 7
`define ADCC_A_BUSY 6
`define ADCC_A_SRC_HI 5
`define ADCC_A_SRC_LO 4
`define ADCC_A_CH_HI 3
`define ADCC_A_CH_LO 0

// control b fields
`define ADCC_B_REF 7
`define ADCC_B_DIV_HI 6
`define ADCC_B_DIV_LO 4
`define ADCC_B_TYP_HI 3
`define ADCC_B_TYP_LO 2
`define ADCC_B_HWTRIG 1
`define ADCC_B_PWR 0

// reset values
`define ADCC_RST_CTRL_A 8'h00
`define ADCC_RST_CTRL_B 8'h20
`define ADCC_RST_DELAY 9'h000
`define ADCC_RST_ACQ 8'h00

// timing counts in converter clocks
`define ADCC_SAMPLE_BASE 9'h006

// encodings
`define ADCC_CH_BANDGAP 4'hF
`define ADCC_CH_LAST 4'h9
`define ADCC_TYP_FALL 2'h0
`define ADCC_TYP_RISE 2'h1
`define ADCC_TYP_CENTRE 2'h2
`define ADCC_TYP_END 2'h3

`endif

/* File: verification/adcc_ctrl_monitor.sv */
// port-level checks of the converter control
// assumes it is bound onto adcc_ctrl; one clock, reset active low
`timescale 1ns/1ps
`default_nettype none
module adcc_ctrl_monitor (
  // bus
  input wire logic pclk, presetn, psel, penable, pwrite, pready, pslverr,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  // converter side
  input wire logic converter_power_on, reference_source_sel, adc_clk_tick,
  input wire logic sample_hold, conv_go,
  input wire logic [10:0] input_connect
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_wr_b;
    psel && penable && pready && pwrite && paddr == 12'h384;
  endsequence
  sequence s_sampled;
    $fell(sample_hold) && converter_power_on;
  endsequence
  a_ready_after_reset: assert property ($past(presetn) |-> pready)
    else $error("bus not ready");
  a_unmapped_error: assert property (psel && penable |-> pslverr == !(paddr
    inside {12'h384, 12'h3A0, 12'h38C, 12'h3C8, 12'h30C, 12'h308}))
    else $error("error response wrong");
  a_ref_power_follow: assert property (s_wr_b |=>
    reference_source_sel == $past(pwdata[7]) &&
    converter_power_on == $past(pwdata[0])) else $error("control b lost");
  a_conn_onehot: assert property ($onehot0(input_connect))
    else $error("two inputs connected");
  a_off_disconnect: assert property (!converter_power_on &&
    !$past(converter_power_on) |-> input_connect == 11'h000)
    else $error("input connected while off");
  a_off_no_tick: assert property (!converter_power_on &&
    !$past(converter_power_on) |-> !adc_clk_tick)
    else $error("clock ticks while off");
  a_sample_min: assert property ($rose(sample_hold) |->
    (sample_hold || !converter_power_on) [*6]) else $error("sampling short");
  a_sample_then_go: assert property (s_sampled |-> ##[0:2] conv_go)
    else $error("no conversion after sampling");
  a_go_single: assert property (conv_go |=> !conv_go [*6])
    else $error("second start too soon");
endmodule // adcc_ctrl_monitor
bind adcc_ctrl adcc_ctrl_monitor adcc_ctrl_monitor_inst (.*);
`default_nettype wire

/* File: verification/adcc_core_model.sv */
// analog core stand-in: answers each start lat+1 cycles after it samples conv_go
// assumes conv_go is a one-cycle pulse on pclk
`timescale 1ns/1ps
`default_nettype none
module adcc_core_model (
  input wire logic pclk, presetn, conv_go,
  input wire logic [9:0] value,
  input wire logic [7:0] lat,
  output logic conv_done,
  output logic [9:0] conv_result
);
  logic run;
  logic [7:0] cnt;
  // result lines toggle outside the done pulse so a late capture shows up
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run <= 1'b0;
      cnt <= 8'h00;
      conv_done <= 1'b0;
      conv_result <= 10'h3FF;
    end else begin
      conv_done <= 1'b0;
      conv_result <= ~conv_result;
      if (conv_go) begin
        run <= 1'b1;
        cnt <= lat;
      end else if (run && cnt == 8'h00) begin
        run <= 1'b0;
        conv_done <= 1'b1;
        conv_result <= value;
      end else if (run) begin
        cnt <= cnt - 8'h01;
      end
    end
  end
endmodule // adcc_core_model
`default_nettype wire

/* File: verification/adcc_ctrl_tb_top.sv */
// self-checking bench of the converter control over apb
// assumes adcc_core_model as analog core; monitor attaches by bind
`timescale 1ns/1ps
`default_nettype none
`include "adcc_regs.vh"
module adcc_ctrl_tb_top;
  localparam logic [7:0] ia = `ADCC_IDX_CTRL_A;
  localparam logic [7:0] ib = `ADCC_IDX_CTRL_B;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic cp, pe, ca, tick, sh, go, pwr, rsel, done;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, seed;
  logic [3:0] pins;
  logic [9:0] res, val;
  logic [10:0] conn;
  logic [7:0] lat;
  int miscompares, tests_run, gos, cyc, g, n;
  adcc_ctrl adcc_ctrl_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .motor_pwm_out_a(pins[0]), .motor_pwm_out_c(pins[1]),
    .motor_pwm_out_e(pins[2]), .external_start_pin(pins[3]),
    .pwm_centre_point(cp), .pwm_period_end(pe), .pwm_centre_aligned(ca),
    .conv_done(done), .conv_result(res), .converter_power_on(pwr),
    .reference_source_sel(rsel), .input_connect(conn), .adc_clk_tick(tick),
    .sample_hold(sh), .conv_go(go));
  adcc_core_model adcc_core_model_inst (.pclk(pclk), .presetn(presetn),
    .conv_go(go), .value(val), .lat(lat), .conv_done(done),
    .conv_result(res));
  // --------------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  function automatic logic [10:0] exp_conn(input logic [3:0] c);
    return c == 4'hF ? 11'h400 : 11'h001 << c;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h, want %h", $time, got, exp);
    end
  endtask
  task automatic complete_run;
    $display("compares %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [7:0] idx,
                     input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdchk(input logic [7:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0);
    chk(rd, exp);
  endtask
  task automatic gap(output int k);
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (tick !== 1'b1);
  endtask
  task automatic wait_done;
    while (done !== 1'b1) @(posedge pclk);
    @(posedge pclk);
  endtask
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  // a hang is cut short here; the whole run needs well under this
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (go === 1'b1) gos <= gos + 1;
    if (cyc == 20000) begin
      miscompares++;
      complete_run;
    end
  end
  initial begin
    {presetn, psel, penable, pwrite, cp, pe, ca, pins} = 11'h000;
    paddr = 12'h000;
    pwdata = 32'h0;
    val = 10'h000;
    lat = 8'h0A;
    seed = 32'h835F041B;
    {miscompares, tests_run, gos, cyc} = 128'h0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(ia, 32'h00);
    rdchk(ib, 32'h20);
    apb(1'b0, 8'h00, 32'h0);
    chk(err, 1'b1);
    for (int d = 0; d < 8; d++) begin
      apb(1'b1, ib, 32'({d[2:0], 4'h1}));
      repeat (2) gap(n);
      gap(n);
      chk(n, 1 << d);
    end
    apb(1'b1, ib, 32'h81);
    @(posedge pclk);
    chk(rsel, 1'b1);
    for (int c = 0; c < 16; c++) if (c < 10 || c == 15) begin
      apb(1'b1, ia, 32'(c));
      repeat (2) @(posedge pclk);
      chk(conn, exp_conn(c[3:0]));
    end
    apb(1'b1, ib, 32'h80);
    repeat (2) @(posedge pclk);
    chk(conn, 11'h000);
    chk(pwr, 1'b0);
    apb(1'b1, `ADCC_IDX_DELAY, 32'h1A5);
    rdchk(`ADCC_IDX_DELAY, 32'h1A5);
    apb(1'b1, `ADCC_IDX_DELAY, 32'h0);
    apb(1'b1, ib, 32'h01);
    apb(1'b1, ia, 32'h03);
    repeat (20) @(posedge pclk);
    chk(gos, 0);
    for (int k = 0; k < 4; k++) begin
      seed = xs(seed);
      val <= seed[9:0];
      lat <= 8'(seed[14:10]) + 8'h08;
      apb(1'b1, `ADCC_IDX_ACQ, 32'(seed[17:15]));
      apb(1'b1, ia, 32'h40);
      rdchk(ia, 32'h40);
      apb(1'b1, ia, 32'h40);
      wait_done;
      rdchk(ia, 32'h80);
      rdchk(`ADCC_IDX_RES_HI, 32'(val[9:2]));
      rdchk(`ADCC_IDX_RES_LO, 32'(val[1:0]));
      apb(1'b1, ia, 32'hC0);
      rdchk(ia, 32'h80);
      apb(1'b1, ia, 32'h00);
      rdchk(ia, 32'h00);
      chk(gos, k + 1);
    end
    lat <= 8'h20;
    for (int s = 0; s < 4; s++) for (int t = 0; t < 2; t++) begin
      apb(1'b1, ib, 32'(1 + 4 * t));
      pins <= {4{~t[0]}};
      apb(1'b1, ia, 32'(s << 4));
      g = gos;
      pins[s] <= t[0];
      repeat (10) @(posedge pclk);
      chk(gos, g);
      apb(1'b1, ib, 32'(3 + 4 * t));
      pins[s] <= ~t[0];
      pins[(s + 1) % 4] <= t[0];
      repeat (10) @(posedge pclk);
      chk(gos, g);
      pins[s] <= t[0];
      repeat (8) @(posedge pclk);
      rdchk(ia, 32'(8'h40 + 16 * s));
      pins[s] <= ~t[0];
      apb(1'b1, ia, 32'(8'h40 + 16 * s));
      pins[s] <= t[0];
      wait_done;
      chk(gos, g + 1);
      apb(1'b1, ia, 32'(s << 4));
    end
    for (int t = 2; t < 4; t++) for (int a = 0; a < 2; a++) begin
      ca <= a[0];
      g = gos;
      apb(1'b1, ib, 32'(3 + 4 * t));
      {pe, cp} <= 2'(1 << (t - 2));
      @(posedge pclk);
      {pe, cp} <= 2'b00;
      repeat (20) @(posedge pclk);
      chk(gos, g + a);
      if (a == 1) begin
        wait_done;
        apb(1'b1, ia, 32'h00);
      end
    end
    complete_run;
  end
endmodule // adcc_ctrl_tb_top
`default_nettype wire
